// File: iemb_params.svh
// Purpose: constants of the interrupt enable mask bank
// Assumes: included by bare name from package and modules
// Notes: addresses are byte offsets on the register bus
`ifndef IEMB_PARAMS_SVH
`define IEMB_PARAMS_SVH

// ==========================================
// bank shape
`define IEMB_NREG 5
`define IEMB_NSRC 80
`define IEMB_ADDR_W 8

// ==========================================
// register offsets
`define IEMB_ENABLE_BASE 8'h00
`define IEMB_FLAG_BASE 8'h20
`define IEMB_REQ_BASE 8'h40
`define IEMB_LEVEL_OFS 8'h60

// ==========================================
// implemented bit masks, one per register
`define IEMB_IMPL0 16'h7fff
`define IEMB_IMPL1 16'hfffb
`define IEMB_IMPL2 16'hdfff
`define IEMB_IMPL3 16'h21ff
`define IEMB_IMPL4 16'h00f6

// ==========================================
// reset values
`define IEMB_ENABLE_RST 16'h0000
`define IEMB_FLAG_RST 16'h0000
`define IEMB_LEVEL_RST 3'h0

`endif

// File: iemb_pkg.sv
// Purpose: shared types and decode functions of the mask bank
// Assumes: iemb_params.svh holds the masks; the five-word bank size is coded here too
// Notes: bank index r, bit b is source r*16+b
`include "iemb_params.svh"

package iemb_pkg;

  // ==========================================
  // types
  typedef logic [15:0] iemb_word_t;
  typedef logic [4:0][15:0] iemb_bank_t;
  typedef enum logic [1:0] {
    IEMB_OKAY = 2'b00,
    IEMB_SLVERR = 2'b10
  } iemb_resp_e;

  // ==========================================
  // implemented bits of one register
  function automatic iemb_word_t iemb_impl(input logic [2:0] idx);
    iemb_word_t m;
    m = 16'h0000;
    case (idx)
      3'h0: m = `IEMB_IMPL0;
      3'h1: m = `IEMB_IMPL1;
      3'h2: m = `IEMB_IMPL2;
      3'h3: m = `IEMB_IMPL3;
      3'h4: m = `IEMB_IMPL4;
      default: m = 16'h0000;
    endcase
    return m;
  endfunction

  // {hit, index} of an address within a five-word block
  function automatic logic [3:0] iemb_sel(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] off;
    off = addr - base;
    return {(addr >= base) && (off[1:0] == 2'h0) && (off[7:2] < 6'h05), off[4:2]};
  endfunction

endpackage

// File: iemb_axil_slave.sv
// Purpose: AXI4-Lite slave front end of the mask bank
// Assumes: one write and one read outstanding at most
// Notes: address and data accepted in either order
`timescale 1ns/1ps
`default_nettype none
`include "iemb_params.svh"

module iemb_axil_slave
  import iemb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`IEMB_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`IEMB_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic wr_en,
  output logic [`IEMB_ADDR_W-1:0] wr_addr,
  output logic [15:0] wr_data,
  output logic [1:0] wr_strb,
  input wire logic wr_err,
  output logic rd_en,
  output logic [`IEMB_ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);

  // ==========================================
  // state
  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [`IEMB_ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [1:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  iemb_resp_e bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;

  // ==========================================
  // handshakes
  assign awready = !aw_hold_reg;
  assign wready = !w_hold_reg;
  assign arready = !rvalid_reg;
  assign wr_en = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_addr = awaddr_reg;
  assign wr_data = wdata_reg;
  assign wr_strb = wstrb_reg;
  assign rd_en = arvalid && !rvalid_reg;
  assign rd_addr = araddr;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next = w_hold_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (wr_en) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_err ? IEMB_SLVERR : IEMB_OKAY;
    end else if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (awvalid && !aw_hold_reg) begin
      aw_hold_next = 1'b1;
      awaddr_next = awaddr;
    end
    if (wvalid && !w_hold_reg) begin
      w_hold_next = 1'b1;
      wdata_next = wdata[15:0];
      wstrb_next = wstrb[1:0];
    end
    if (rd_en) begin
      rvalid_next = 1'b1;
      rdata_next = rd_err ? 32'h0000_0000 : rd_data;
      rresp_next = rd_err ? IEMB_SLVERR : IEMB_OKAY;
    end else if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 16'h0000;
      wstrb_reg <= 2'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= IEMB_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= IEMB_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

endmodule

`default_nettype wire

// File: iemb_gate.sv
// Purpose: masks flags with enables and priorities, finds top level
// Assumes: priority fields come from the priority registers outside
// Notes: one cycle from inputs to registered outputs
`timescale 1ns/1ps
`default_nettype none
`include "iemb_params.svh"

module iemb_gate
  import iemb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`IEMB_NSRC-1:0] flag_bits,
  input wire logic [`IEMB_NSRC-1:0] enable_bits,
  input wire logic [3*`IEMB_NSRC-1:0] prio_level,
  output logic [`IEMB_NSRC-1:0] req_reg,
  output logic [2:0] level_reg,
  output logic any_reg
);

  logic [`IEMB_NSRC-1:0] req_next, prio_nz;
  logic [2:0] level_next;
  logic any_next;

  // ==========================================
  // masking and level search
  always_comb begin
    level_next = `IEMB_LEVEL_RST;
    for (int i = 0; i < `IEMB_NSRC; i++) begin
      prio_nz[i] = |prio_level[3*i +: 3];
      req_next[i] = flag_bits[i] && enable_bits[i] && prio_nz[i];
      if (req_next[i] && (prio_level[3*i +: 3] > level_next)) begin
        level_next = prio_level[3*i +: 3];
      end
    end
    any_next = |req_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_reg <= '0;
      level_reg <= `IEMB_LEVEL_RST;
      any_reg <= 1'b0;
    end else begin
      req_reg <= req_next;
      level_reg <= level_next;
      any_reg <= any_next;
    end
  end

  // ==========================================
  // checks
  a_req_needs_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    1 |=> ((req_reg & ~$past(enable_bits)) == '0))
    else $error("request passed with enable clear");
  a_prio_zero_block: assert property (@(posedge aclk) disable iff (!aresetn)
    1 |=> ((req_reg & ~$past(prio_nz)) == '0))
    else $error("request passed with priority zero");
  a_level_any: assert property (@(posedge aclk) disable iff (!aresetn)
    any_reg == (level_reg != 3'h0))
    else $error("level disagrees with pending request");

endmodule

`default_nettype wire

// File: iemb_top.sv
// Purpose: interrupt enable mask bank with flags behind AXI4-Lite
// Assumes: source pulses and priority fields synchronous to aclk
// Notes: requests reach the arbiter one cycle after the flag
//
// How it works
// - a set enable bit passes its source's request, a clear bit blocks it
// - all implemented enable bits clear to zero at reset
// - unimplemented bit positions ignore writes and read zero
// - implemented enable bits read back the value last written
// - register 0 bits 2..0 gate compare 1, capture 1, external pin 0
// - register 1 bits 15..8 gate uart2 tx/rx, pin 2, timers 5/4, compares, dma 2
// - register 1 bits 7..3 captures 8/7, adc2, pin 1, pin change; 2 absent; i2c1
// - register 2 bits 15..8 timer 6, dma 4, bit 13 absent, compares 8..5, capture 6
// - register 2 bits 7..0 captures 5..3, dma 3, can1 event/rx, spi2 event/error
// - register 3 bits 15-14 and 12-9 absent; dma 5 and can2 event kept
// - register 3 bits 7..0 can2 rx, pins 4/3, timers 9/8, i2c2, timer 7
// - register 4 upper byte, bits 3, 0 absent; can tx, dma 7/6, uart errors
// - each source flag reads one once its request occurred
// - a zero priority field blocks the source even when enabled
// - priority seven is highest, one is lowest
`timescale 1ns/1ps
`default_nettype none
`include "iemb_params.svh"

module iemb_top
  import iemb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`IEMB_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`IEMB_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic [`IEMB_NSRC-1:0] src_pulse,
  input wire logic [3*`IEMB_NSRC-1:0] prio_level,
  output logic [`IEMB_NSRC-1:0] irq_enable,
  output logic [`IEMB_NSRC-1:0] irq_req,
  output logic [2:0] irq_level,
  output logic irq_any
);

  // ==========================================
  // bus front end
  logic wr_en, wr_err, rd_en, rd_err;
  logic [`IEMB_ADDR_W-1:0] wr_addr, rd_addr;
  logic [15:0] wr_data;
  logic [1:0] wr_strb;
  logic [31:0] rd_data;

  iemb_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .awaddr(s_axi_awaddr),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .bresp(s_axi_bresp),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .araddr(s_axi_araddr),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // ==========================================
  // byte lane merge
  function automatic iemb_word_t lane_merge(input iemb_word_t old_w, input iemb_word_t new_w,
                                            input logic [1:0] strb);
    return {strb[1] ? new_w[15:8] : old_w[15:8], strb[0] ? new_w[7:0] : old_w[7:0]};
  endfunction

  // ==========================================
  // enable and flag banks
  iemb_bank_t enable_reg, enable_next, flag_reg, flag_next, src_bank, impl_bank;
  logic [3:0] wr_en_sel, wr_fl_sel;
  logic [2:0] level_w;
  logic any_w;
  logic [`IEMB_NSRC-1:0] req_w;

  assign src_bank = src_pulse;

  always_comb begin
    for (int r = 0; r < `IEMB_NREG; r++) begin
      impl_bank[r] = iemb_impl(r[2:0]);
    end
  end

  always_comb begin
    enable_next = enable_reg;
    flag_next = flag_reg;
    wr_en_sel = iemb_sel(wr_addr, `IEMB_ENABLE_BASE);
    wr_fl_sel = iemb_sel(wr_addr, `IEMB_FLAG_BASE);
    wr_err = !(wr_en_sel[3] || wr_fl_sel[3]);
    if (wr_en && wr_en_sel[3]) begin
      enable_next[wr_en_sel[2:0]] = lane_merge(enable_reg[wr_en_sel[2:0]], wr_data, wr_strb)
                                    & impl_bank[wr_en_sel[2:0]];
    end else if (wr_en && wr_fl_sel[3]) begin
      flag_next[wr_fl_sel[2:0]] = lane_merge(flag_reg[wr_fl_sel[2:0]], wr_data, wr_strb)
                                  & impl_bank[wr_fl_sel[2:0]];
    end
    for (int r = 0; r < `IEMB_NREG; r++) begin
      flag_next[r] = flag_next[r] | (src_bank[r] & impl_bank[r]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int r = 0; r < `IEMB_NREG; r++) begin
        enable_reg[r] <= `IEMB_ENABLE_RST;
        flag_reg[r] <= `IEMB_FLAG_RST;
      end
    end else begin
      enable_reg <= enable_next;
      flag_reg <= flag_next;
    end
  end

  assign irq_enable = enable_reg;

  // ==========================================
  // masking toward arbitration
  iemb_gate u_gate (
    .aclk(aclk),
    .aresetn(aresetn),
    .flag_bits(flag_reg),
    .enable_bits(enable_reg),
    .prio_level(prio_level),
    .req_reg(req_w),
    .level_reg(level_w),
    .any_reg(any_w)
  );

  assign irq_req = req_w;
  assign irq_level = level_w;
  assign irq_any = any_w;

  // ==========================================
  // read decode
  logic [3:0] rd_en_sel, rd_fl_sel, rd_rq_sel;
  iemb_bank_t req_bank;

  assign req_bank = req_w;

  always_comb begin
    rd_en_sel = iemb_sel(rd_addr, `IEMB_ENABLE_BASE);
    rd_fl_sel = iemb_sel(rd_addr, `IEMB_FLAG_BASE);
    rd_rq_sel = iemb_sel(rd_addr, `IEMB_REQ_BASE);
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (rd_en_sel[3]) begin
      rd_data = {16'h0000, enable_reg[rd_en_sel[2:0]]};
    end else if (rd_fl_sel[3]) begin
      rd_data = {16'h0000, flag_reg[rd_fl_sel[2:0]]};
    end else if (rd_rq_sel[3]) begin
      rd_data = {16'h0000, req_bank[rd_rq_sel[2:0]]};
    end else if (rd_addr == `IEMB_LEVEL_OFS) begin
      rd_data = {28'h000_0000, any_w, level_w};
    end else begin
      rd_err = 1'b1;
    end
  end

  // ==========================================
  // checks
  iemb_bank_t set_vec;
  assign set_vec = src_bank & impl_bank;

  sequence s_write_taken;
    wr_en && wr_en_sel[3] && (wr_strb == 2'h3);
  endsequence

  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_reset_masks: assert property (@(posedge aclk)
    !aresetn |=> (enable_reg == '0) && (irq_req == '0))
    else $error("enables not cleared by reset");

  a_absent_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    ((enable_reg & ~impl_bank) == '0) && ((flag_reg & ~impl_bank) == '0))
    else $error("unimplemented bit holds a one");

  a_write_back: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_taken |=> enable_reg[$past(wr_en_sel[2:0])] == ($past(wr_data)
                      & impl_bank[$past(wr_en_sel[2:0])]))
    else $error("enable register missed a write");

  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_read_taken ##0 (rd_en_sel[3] == 1'b1) |=> s_axi_rvalid &&
      (s_axi_rdata == {16'h0000, $past(enable_reg[rd_en_sel[2:0]])}))
    else $error("enable read returned wrong data");

  a_flag_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    1 |=> ((flag_reg & $past(set_vec)) == $past(set_vec)))
    else $error("source pulse lost");

  a_map_reg0: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_taken ##0 (wr_en_sel[2:0] == 3'h0) |=> (irq_enable[2:0] == $past(wr_data[2:0]))
      && (irq_enable[15] == 1'b0))
    else $error("register 0 map broken");

  a_map_holes: assert property (@(posedge aclk) disable iff (!aresetn)
    (irq_enable[18] == 1'b0) && (irq_enable[45] == 1'b0) && (irq_enable[79:72] == 8'h00))
    else $error("absent enable bit set");

  a_mask_path: assert property (@(posedge aclk) disable iff (!aresetn)
    1 |=> ((irq_req & ~$past(flag_reg & enable_reg)) == '0))
    else $error("request without flag and enable");

  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en |=> s_axi_bvalid && (s_axi_bresp == ($past(wr_err) ? 2'b10 : 2'b00)))
    else $error("write response missing");

endmodule

`default_nettype wire

// File: iemb_src_model.sv
// Purpose: far-side model of interrupt sources and priority fields
// Assumes: bench drives go, idx, prio on aclk edges
// Notes: one request pulse per go, priority field kept per source
`timescale 1ns/1ps
`default_nettype none
`include "iemb_params.svh"

module iemb_src_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic [6:0] idx,
  input wire logic [2:0] prio,
  output logic [`IEMB_NSRC-1:0] src_pulse,
  output logic [3*`IEMB_NSRC-1:0] prio_level
);
  // ==========================================
  // pulse and priority fields
  always_ff @(posedge aclk) begin
    src_pulse <= '0;
    if (!aresetn) begin
      prio_level <= '0;
    end else if (go) begin
      prio_level[3*idx +: 3] <= prio;
      src_pulse[idx] <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: tb.sv
// Purpose: self-checking bench of the interrupt enable mask bank
// Assumes: offsets and implemented masks from iemb_params.svh
// Notes: random enables, sources and priorities from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "iemb_params.svh"

module tb
  import iemb_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp;
  logic go = 1'b0;
  logic [6:0] idx = 7'h00;
  logic [2:0] prio = 3'h0;
  logic [79:0] src_pulse, irq_enable, irq_req;
  logic [239:0] prio_level;
  logic [2:0] irq_level;
  logic irq_any;
  logic [15:0] en [5];
  int num_errors = 0, comparisons = 0, cycles = 0, seed = 2;

  always #50 aclk = ~aclk;

  iemb_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .src_pulse(src_pulse), .prio_level(prio_level),
    .irq_enable(irq_enable), .irq_req(irq_req), .irq_level(irq_level),
    .irq_any(irq_any));

  iemb_src_model src_model (.aclk(aclk), .aresetn(aresetn), .go(go), .idx(idx),
    .prio(prio), .src_pulse(src_pulse), .prio_level(prio_level));

  // ==========================================
  // helpers
  function automatic logic [15:0] impl(input int r);
    case (r)
      0: return `IEMB_IMPL0;
      1: return `IEMB_IMPL1;
      2: return `IEMB_IMPL2;
      3: return `IEMB_IMPL3;
      default: return `IEMB_IMPL4;
    endcase
  endfunction

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [15:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {16'h0000, d};
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic set_en(input int r, input logic [15:0] w);
    logic [1:0] resp;
    logic [31:0] d;
    axi_write(`IEMB_ENABLE_BASE + 8'(4*r), w, resp);
    check("enable write resp", {30'h0, IEMB_OKAY}, {30'h0, resp});
    en[r] = w & impl(r);
    axi_read(`IEMB_ENABLE_BASE + 8'(4*r), d, resp);
    check("enable readback", {16'h0, en[r]}, d);
    check("enable read resp", {30'h0, IEMB_OKAY}, {30'h0, resp});
    check("enable port", {16'h0, en[r]}, {16'h0, irq_enable[16*r +: 16]});
  endtask

  task automatic fire(input int i, input logic [2:0] p);
    @(posedge aclk);
    go <= 1'b1;
    idx <= 7'(i);
    prio <= p;
    @(posedge aclk);
    go <= 1'b0;
  endtask

  // ==========================================
  // timeout
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      stop_test;
    end
  end

  // ==========================================
  // main sequence
  initial begin
    logic [1:0] resp;
    logic [31:0] d;
    logic [2:0] p;
    logic hit;
    int i, r, k;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (r = 0; r < 5; r++) begin
      axi_read(`IEMB_ENABLE_BASE + 8'(4*r), d, resp);
      check("enable reset", 32'h0, d);
    end
    for (k = 0; k < 3; k++) begin
      for (r = 0; r < 5; r++) begin
        set_en(r, k == 0 ? 16'hffff : k == 1 ? 16'h0000 : 16'($random(seed)));
      end
    end
    for (k = 0; k < 40; k++) begin
      i = {$random(seed)} % 80;
      p = k < 8 ? 3'(k) : 3'($random(seed));
      set_en(i / 16, 16'($random(seed)));
      fire(i, p);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      hit = en[i/16][i%16] && (p != 3'h0);
      check("forwarded request", {31'h0, hit}, {31'h0, irq_req[i]});
      check("level", hit ? {29'h0, p} : 32'h0, {29'h0, irq_level});
      check("any", {31'h0, hit}, {31'h0, irq_any});
      axi_read(`IEMB_FLAG_BASE + 8'(4*(i/16)), d, resp);
      check("flag", (32'(impl(i/16)) >> (i%16)) & 32'h1, {31'h0, d[i%16]});
      axi_write(`IEMB_FLAG_BASE + 8'(4*(i/16)), 16'h0000, resp);
    end
    set_en(0, 16'hffff);
    wstrb <= 4'h2;
    axi_write(`IEMB_ENABLE_BASE, 16'h0000, resp);
    wstrb <= 4'hf;
    axi_read(`IEMB_ENABLE_BASE, d, resp);
    check("lane write", 32'h0000_00ff, d);
    for (r = 0; r < 2; r++) set_en(r, 16'hffff);
    fire(0, 3'h3);
    fire(16, 3'h6);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check("top level", 32'h6, {29'h0, irq_level});
    axi_write(8'h40, 16'hffff, resp);
    check("ro write resp", {30'h0, IEMB_SLVERR}, {30'h0, resp});
    axi_read(8'h14, d, resp);
    check("hole read data", 32'h0, d);
    check("hole read resp", {30'h0, IEMB_SLVERR}, {30'h0, resp});
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(`IEMB_ENABLE_BASE + 8'h04, d, resp);
    check("enable after reset", 32'h0, d);
    check("enable port reset", 32'h0, {16'h0, irq_enable[15:0] | irq_enable[31:16]});
    check("any after reset", 32'h0, {31'h0, irq_any});
    stop_test;
  end
endmodule
`default_nettype wire
